// ### design/eec_params.svh
// Named constants of the data EEPROM controller: offsets, bit positions, keys and timing.
`ifndef EEC_PARAMS_SVH
`define EEC_PARAMS_SVH

// Byte offsets of the registers on the bus.
`define EEC_OFS_DATA     8'h00
`define EEC_OFS_ADDR     8'h04
`define EEC_OFS_CTRL     8'h08
`define EEC_OFS_UNLOCK   8'h0c
`define EEC_OFS_IRQ      8'h10

// Bit positions in the control register.
`define EEC_CTRL_RD      0
`define EEC_CTRL_WR      1
`define EEC_CTRL_WRITE_ALLOW    2
`define EEC_CTRL_WRITE_ABORT_FLAG   3

// Bit positions in the interrupt control register.
`define EEC_IRQ_FLAG     0
`define EEC_IRQ_IE       1
`define EEC_IRQ_GATE     2
`define EEC_IRQ_GIE      3

// Unlock keys and reset values.
`define EEC_KEY_FIRST    8'h55
`define EEC_KEY_SECOND   8'haa
`define EEC_BYTE_ZERO    8'h00
`define EEC_WORD_ZERO    32'h0000_0000

// Timing: clock rate, power-up hold-off and self-timed write length.
`define EEC_CLK_MHZ      200
`define EEC_PWRT_MS      64
`define EEC_PWRT_CYCLES  (`EEC_PWRT_MS * 1000 * `EEC_CLK_MHZ)
`define EEC_WRITE_US     5
`define EEC_WRITE_CYCLES (`EEC_WRITE_US * `EEC_CLK_MHZ)

// Counter widths.
`define EEC_WCNT_W       16
`define EEC_PCNT_W       24

`endif

// ### design/eec_pkg.sv
// Types shared by the data EEPROM controller: register selects, unlock states, state record.
`include "eec_params.svh"

package eec_pkg;

  typedef enum logic [2:0] {
    EEC_REG_NONE   = 3'h0,
    EEC_REG_DATA   = 3'h1,
    EEC_REG_ADDR   = 3'h2,
    EEC_REG_CTRL   = 3'h3,
    EEC_REG_UNLOCK = 3'h4,
    EEC_REG_IRQ    = 3'h5
  } eec_reg_t;

  // Gray-coded progress through the unlock keys.
  typedef enum logic [1:0] {
    EEC_UNL_IDLE = 2'b00,
    EEC_UNL_KEY1 = 2'b01,
    EEC_UNL_KEY2 = 2'b11
  } eec_unlock_t;

  typedef struct packed {
    logic                   hreadyout;
    logic [31:0]            hrdata;
    logic                   pend_wr;
    logic                   pend_rd;
    eec_reg_t               pend_sel;
    logic [7:0]             data;
    logic [7:0]             addr;
    logic                   rd;
    logic                   wr;
    logic                   wr_allow;
    logic                   wr_abort;
    logic                   wc_flag;
    logic                   wc_ie;
    logic                   pe_gate;
    logic                   global_irq_enable;
    eec_unlock_t            unl;
    logic [`EEC_WCNT_W-1:0] wcnt;
    logic [`EEC_PCNT_W-1:0] pcnt;
    logic                   irq;
    logic [7:0]             prog_rdata;
  } eec_state_t;

endpackage

// ### design/eec_top.sv
// Data EEPROM controller with an AHB-Lite register slave and a self-timed byte write.
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

`include "eec_params.svh"

module eec_top #(
  parameter int ADDR_BITS    = 8,
  parameter int WRITE_CYCLES = `EEC_WRITE_CYCLES,
  parameter int PWRT_CYCLES  = `EEC_PWRT_CYCLES
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  external_master_reset,
  input  wire logic                  watchdog_reset,
  input  wire logic                  brownout_reset,
  input  wire logic                  data_protect_fuse,
  input  wire logic [7:0]            prog_addr,
  output logic [7:0]                 prog_rdata,
  output logic                       write_busy,
  output logic                       eeprom_irq
);
  import eec_pkg::*;

  localparam int                     DEPTH     = 1 << ADDR_BITS;
  localparam logic [7:0]             ADDR_MASK = 8'(DEPTH - 1);
  localparam logic [`EEC_WCNT_W-1:0] WR_LOAD   = `EEC_WCNT_W'(WRITE_CYCLES);
  localparam logic [`EEC_PCNT_W-1:0] PWRT_LOAD = `EEC_PCNT_W'(PWRT_CYCLES);
  localparam logic [`EEC_WCNT_W-1:0] WR_LAST   = `EEC_WCNT_W'(1);

  eec_state_t  st_ff;
  eec_state_t  nxt_st;
  logic [7:0]  mem [DEPTH];
  logic        any_rst;
  logic        accept;
  logic        mem_we;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;
  logic [7:0]  prog_byte;

  // Maps a bus address onto a register select; unmapped words give none.
  function automatic eec_reg_t eec_decode(input logic [31:0] a);
    case (a[7:0])
      `EEC_OFS_DATA:   eec_decode = EEC_REG_DATA;
      `EEC_OFS_ADDR:   eec_decode = EEC_REG_ADDR;
      `EEC_OFS_CTRL:   eec_decode = EEC_REG_CTRL;
      `EEC_OFS_UNLOCK: eec_decode = EEC_REG_UNLOCK;
      `EEC_OFS_IRQ:    eec_decode = EEC_REG_IRQ;
      default:         eec_decode = EEC_REG_NONE;
    endcase
    if (a[31:8] != 24'h00_0000) begin
      eec_decode = EEC_REG_NONE;
    end
  endfunction

  // Builds the read word of one register from the current state.
  function automatic logic [31:0] eec_read(input eec_reg_t sel, input eec_state_t s);
    eec_read = `EEC_WORD_ZERO;
    case (sel)
      EEC_REG_DATA: eec_read[7:0] = s.data;
      EEC_REG_ADDR: eec_read[7:0] = s.addr & ADDR_MASK;
      EEC_REG_CTRL: begin
        eec_read[`EEC_CTRL_RD]    = s.rd;
        eec_read[`EEC_CTRL_WR]    = s.wr;
        eec_read[`EEC_CTRL_WRITE_ALLOW]  = s.wr_allow;
        eec_read[`EEC_CTRL_WRITE_ABORT_FLAG] = s.wr_abort;
      end
      EEC_REG_IRQ: begin
        eec_read[`EEC_IRQ_FLAG] = s.wc_flag;
        eec_read[`EEC_IRQ_IE]   = s.wc_ie;
        eec_read[`EEC_IRQ_GATE] = s.pe_gate;
        eec_read[`EEC_IRQ_GIE]  = s.global_irq_enable;
      end
      default: eec_read = `EEC_WORD_ZERO;
    endcase
  endfunction

  // Bus qualifiers, write data byte and array read ports.
  assign any_rst   = external_master_reset | watchdog_reset | brownout_reset;
  assign accept    = hsel & htrans[1] & hready;
  assign wbyte     = hwdata[7:0];
  assign rd_byte   = mem[st_ff.addr[ADDR_BITS-1:0]];
  assign prog_byte = mem[prog_addr[ADDR_BITS-1:0]];
  assign mem_we    = st_ff.wr & (st_ff.wcnt == WR_LAST) & ~any_rst;

  // Next state: bus phases, register effects, write timer and resets.
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.rd) begin
      nxt_st.rd = 1'b0;
    end
    if (st_ff.pcnt != '0) begin
      nxt_st.pcnt = st_ff.pcnt - 1'b1;
    end
    // Read data phase: one wait cycle, then the word stands with ready.
    if (st_ff.pend_rd) begin
      nxt_st.hrdata    = eec_read(st_ff.pend_sel, st_ff);
      nxt_st.hreadyout = 1'b1;
      nxt_st.pend_rd   = 1'b0;
      nxt_st.unl       = EEC_UNL_IDLE;
    end
    // Write data phase: the byte lands on the selected register.
    if (st_ff.pend_wr) begin
      nxt_st.pend_wr = 1'b0;
      nxt_st.unl     = EEC_UNL_IDLE;
      case (st_ff.pend_sel)
        EEC_REG_DATA: nxt_st.data = wbyte;
        EEC_REG_ADDR: nxt_st.addr = wbyte & ADDR_MASK;
        EEC_REG_UNLOCK: begin
          if (wbyte == `EEC_KEY_FIRST) begin
            nxt_st.unl = EEC_UNL_KEY1;
          end else if (wbyte == `EEC_KEY_SECOND && st_ff.unl == EEC_UNL_KEY1) begin
            nxt_st.unl = EEC_UNL_KEY2;
          end
        end
        EEC_REG_CTRL: begin
          nxt_st.wr_allow = wbyte[`EEC_CTRL_WRITE_ALLOW];
          nxt_st.wr_abort = wbyte[`EEC_CTRL_WRITE_ABORT_FLAG];
          if (wbyte[`EEC_CTRL_RD] && !st_ff.wr) begin
            nxt_st.rd   = 1'b1;
            nxt_st.data = rd_byte;
          end
          if (wbyte[`EEC_CTRL_WR] && st_ff.wr_allow && st_ff.unl == EEC_UNL_KEY2
              && st_ff.pcnt == '0 && !st_ff.wr) begin
            nxt_st.wr   = 1'b1;
            nxt_st.wcnt = WR_LOAD;
          end
        end
        EEC_REG_IRQ: begin
          nxt_st.wc_flag = wbyte[`EEC_IRQ_FLAG];
          nxt_st.wc_ie   = wbyte[`EEC_IRQ_IE];
          nxt_st.pe_gate = wbyte[`EEC_IRQ_GATE];
          nxt_st.global_irq_enable     = wbyte[`EEC_IRQ_GIE];
        end
        default: nxt_st.unl = EEC_UNL_IDLE;
      endcase
    end
    // Address phase: capture the select; reads insert one wait cycle.
    if (accept) begin
      nxt_st.pend_sel = eec_decode(haddr);
      nxt_st.pend_wr  = hwrite;
      nxt_st.pend_rd  = ~hwrite;
      if (!hwrite) begin
        nxt_st.hreadyout = 1'b0;
      end
    end
    // Self-timed write; completion sets the flag after any software write.
    if (st_ff.wr) begin
      if (st_ff.wcnt == WR_LAST) begin
        nxt_st.wr       = 1'b0;
        nxt_st.wc_flag  = 1'b1;
        nxt_st.wr_abort = 1'b0;
      end else begin
        nxt_st.wcnt = st_ff.wcnt - 1'b1;
      end
    end
    // Warm resets abort a running write and clear the indirect registers.
    if (any_rst) begin
      if (st_ff.wr) begin
        nxt_st.wr_abort = 1'b1;
      end
      nxt_st.wr      = 1'b0;
      nxt_st.rd      = 1'b0;
      nxt_st.data    = `EEC_BYTE_ZERO;
      nxt_st.addr    = `EEC_BYTE_ZERO;
      nxt_st.unl     = EEC_UNL_IDLE;
      nxt_st.wc_flag = 1'b0;
      nxt_st.wc_ie   = 1'b0;
      nxt_st.pe_gate = 1'b0;
      nxt_st.global_irq_enable     = 1'b0;
      if (brownout_reset) begin
        nxt_st.pcnt = PWRT_LOAD;
      end
    end
    nxt_st.irq        = st_ff.wc_flag & st_ff.wc_ie & st_ff.pe_gate & st_ff.global_irq_enable;
    nxt_st.prog_rdata = data_protect_fuse ? prog_byte : `EEC_BYTE_ZERO;
  end

  // State register; power-on reset clears write-allow and starts the hold-off.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff           <= '0;
      st_ff.hreadyout <= 1'b1;
      st_ff.pend_sel  <= EEC_REG_NONE;
      st_ff.unl       <= EEC_UNL_IDLE;
      st_ff.wr_allow  <= 1'b0;
      st_ff.pcnt      <= PWRT_LOAD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Byte array: a finished write replaces the whole location in one step.
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem[st_ff.addr[ADDR_BITS-1:0]] <= st_ff.data;
    end
  end

  // Outputs straight from the state register; the response is always OKAY.
  assign hreadyout  = st_ff.hreadyout;
  assign hresp      = 1'b0;
  assign hrdata     = st_ff.hrdata;
  assign prog_rdata = st_ff.prog_rdata;
  assign write_busy = st_ff.wr;
  assign eeprom_irq = st_ff.irq;

  // Checks on the control bits, sequence and timing.
  chk_rd_self_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.rd && !(st_ff.pend_wr && st_ff.pend_sel == EEC_REG_CTRL && wbyte[`EEC_CTRL_RD]))
      |=> !st_ff.rd)
    else $error("read start did not self-clear");

  chk_abort_on_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.wr && any_rst) |=> (st_ff.wr_abort && !st_ff.wr))
    else $error("interrupted write did not set the abort flag");

  chk_reset_clears_regs: assert property (@(posedge hclk) disable iff (!hresetn)
    any_rst |=> (st_ff.addr == `EEC_BYTE_ZERO && st_ff.data == `EEC_BYTE_ZERO))
    else $error("address or data survived a warm reset");

  chk_wr_needs_allow: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_ff.wr) |-> $past(st_ff.wr_allow))
    else $error("write started without write-allow");

  chk_wr_unlocked: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_ff.wr) |-> ($past(st_ff.unl) == EEC_UNL_KEY2 && $past(st_ff.pend_wr)))
    else $error("write started without the unlock keys");

  chk_write_runs: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.wr && st_ff.wcnt != WR_LAST && !any_rst) |=> (st_ff.wr && $changed(st_ff.wcnt)))
    else $error("running write stopped early");

  chk_write_done: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.wr && st_ff.wcnt == WR_LAST && !any_rst) |=> (!st_ff.wr && st_ff.wc_flag)
      ##1 (st_ff.wc_flag || $past(st_ff.pend_wr) || $past(any_rst)))
    else $error("write end did not set the completion flag");

  chk_pwrt_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.pcnt != '0) |=> !$rose(st_ff.wr))
    else $error("write started during the power-up hold-off");

  chk_prog_protect: assert property (@(posedge hclk) disable iff (!hresetn)
    !data_protect_fuse |=> (prog_rdata == `EEC_BYTE_ZERO))
    else $error("protected array visible on the programmer port");

  chk_irq_gating: assert property (@(posedge hclk) disable iff (!hresetn)
    eeprom_irq |-> $past(st_ff.wc_flag && st_ff.wc_ie && st_ff.pe_gate && st_ff.global_irq_enable))
    else $error("interrupt raised without flag, enable and gates");

  // Checks that only the intended events move the set-only and software bits.
  chk_wr_set_only: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(st_ff.wr)
      |-> $past((st_ff.wcnt == WR_LAST) || any_rst))
    else $error("write start cleared before the write ended");

  chk_allow_sw_only: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(st_ff.wr_allow)
      |-> $past(st_ff.pend_wr && st_ff.pend_sel == EEC_REG_CTRL))
    else $error("write-allow changed without a control write");

  chk_abort_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_ff.wr_abort)
      |-> $past((st_ff.wr && any_rst) || (st_ff.pend_wr && st_ff.pend_sel == EEC_REG_CTRL)))
    else $error("abort flag set without an interrupted write");

  chk_data_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(st_ff.data)
      |-> $past(any_rst || (st_ff.pend_wr && (st_ff.pend_sel == EEC_REG_DATA
                                              || st_ff.pend_sel == EEC_REG_CTRL))))
    else $error("data register changed without a read or a write");

  // Checks on the read path: array fetch, unlock word and control word.
  chk_read_fetch: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_ff.rd)
      |-> (st_ff.data == $past(rd_byte)))
    else $error("read start did not fetch the addressed byte");

  chk_unlock_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.pend_rd && st_ff.pend_sel == EEC_REG_UNLOCK)
      |=> (hrdata == `EEC_WORD_ZERO))
    else $error("unlock register read back a value");

  chk_ctrl_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.pend_rd && st_ff.pend_sel == EEC_REG_CTRL)
      |=> (hrdata[31:`EEC_CTRL_WRITE_ABORT_FLAG+1] == '0))
    else $error("unimplemented control bits read as one");

  // Checks on the address mask, write timer, hold-off, interrupt and programmer port.
  chk_addr_top_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.addr & ~ADDR_MASK) == `EEC_BYTE_ZERO)
    else $error("address holds a bit beyond the array");

  chk_write_length: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.wr
      |-> (st_ff.wcnt != '0 && st_ff.wcnt <= WR_LOAD))
    else $error("write timer outside its load range");

  chk_brownout_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    brownout_reset
      |=> (st_ff.pcnt == PWRT_LOAD))
    else $error("brownout did not restart the hold-off");

  chk_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.wc_flag && st_ff.wc_ie && st_ff.pe_gate && st_ff.global_irq_enable)
      |=> eeprom_irq)
    else $error("interrupt missing with flag, enable and gates set");

  chk_prog_open: assert property (@(posedge hclk) disable iff (!hresetn)
    data_protect_fuse
      |=> (prog_rdata == $past(prog_byte)))
    else $error("programmer port did not show the addressed byte");

endmodule

// ### testbench/data_eeprom_controller_tb.sv
// Self-checking bench of the data EEPROM controller, driven over its register bus.
`timescale 1ns/1ps
`include "eec_params.svh"
module data_eeprom_controller_tb;
  localparam int WCYC = 8;
  localparam logic [31:0] A_DAT = {24'h0, `EEC_OFS_DATA};
  localparam logic [31:0] A_ADR = {24'h0, `EEC_OFS_ADDR};
  localparam logic [31:0] A_CTL = {24'h0, `EEC_OFS_CTRL};
  localparam logic [31:0] A_UNL = {24'h0, `EEC_OFS_UNLOCK};
  localparam logic [31:0] A_IRQ = {24'h0, `EEC_OFS_IRQ};
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } eec_row_t;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        mrst, wrst, brst, fuse, write_busy, eeprom_irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd_val;
  logic [7:0]  prog_addr, prog_rdata;
  logic [7:0]  k1s [3] = '{8'h55, 8'h55, 8'haa};
  logic [7:0]  k2s [3] = '{8'haa, 8'h55, 8'h55};
  int          bad_count, comparisons, n;
  // Register cases and one unmapped word: address, value written, value read back.
  eec_row_t    rows [7] = '{
    '{A_DAT, 32'h0000_01a5, 32'h0000_00a5},
    '{A_ADR, 32'hffff_ff5a, 32'h0000_005a},
    '{A_CTL, 32'h0000_00fc, 32'h0000_000c},
    '{A_CTL, 32'h0000_0000, 32'h0000_0000},
    '{A_UNL, 32'h0000_0055, 32'h0000_0000},
    '{A_IRQ, 32'h0000_000e, 32'h0000_000e},
    '{32'h20, 32'h0000_00ff, 32'h0000_0000}
  };

  // Clock of 200 MHz.
  always #2.5 hclk = ~hclk;

  eec_top #(.ADDR_BITS(8), .WRITE_CYCLES(WCYC), .PWRT_CYCLES(20)) uut (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .hsel                  (hsel),
    .haddr                 (haddr),
    .htrans                (htrans),
    .hwrite                (hwrite),
    .hsize                 (hsize),
    .hwdata                (hwdata),
    .hready                (hreadyout),
    .hreadyout             (hreadyout),
    .hresp                 (hresp),
    .hrdata                (hrdata),
    .external_master_reset (mrst),
    .watchdog_reset        (wrst),
    .brownout_reset        (brst),
    .data_protect_fuse     (fuse),
    .prog_addr             (prog_addr),
    .prog_rdata            (prog_rdata),
    .write_busy            (write_busy),
    .eeprom_irq            (eeprom_irq)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits for an edge with ready high; a stuck bus ends the run.
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 20) begin
        bad_count++;
        $display("unexpected bus wait: expected ready seen stall");
        results();
      end
      @(posedge hclk);
    end
  endtask

  // One single word transfer; read data is taken at the closing edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd_val = hrdata;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd_val);
  endtask

  task automatic seq(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
    bus(1'b1, A_UNL, {24'h0, k1});
    bus(1'b1, A_UNL, {24'h0, k2});
    bus(1'b1, A_CTL, {24'h0, c});
  endtask

  // Loads address and data and sets write-allow.
  task automatic prep(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, A_ADR, {24'h0, a});
    bus(1'b1, A_DAT, {24'h0, d});
    bus(1'b1, A_CTL, 32'h4);
  endtask

  task automatic ee_read(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b1, A_ADR, {24'h0, a});
    bus(1'b1, A_CTL, 32'h1);
    rd(A_DAT, {24'h0, exp}, "eeprom byte");
  endtask

  // Counts cycles until the write finishes, with a bound.
  task automatic wait_done();
    n = 0;
    while (write_busy === 1'b1) begin
      if (n >= 100) begin
        bad_count++;
        $display("unexpected write wait: expected idle seen busy");
        results();
      end
      @(posedge hclk);
      #1;
      n++;
    end
  endtask

  // Main sequence: reset, register table, then the awkward cases.
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    {mrst, wrst, brst} = 3'b000;
    fuse = 1'b0;
    prog_addr = 8'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    check("busy at reset", 32'h0, {31'h0, write_busy});
    rd(A_CTL, 32'h0, "control at reset");
    bus(1'b1, A_CTL, 32'h4);
    seq(8'h55, 8'haa, 8'h06);
    rd(A_CTL, 32'h4, "control in hold-off");
    rd(A_DAT, 32'h0, "data at reset");
    rd(A_ADR, 32'h0, "address at reset");
    repeat (30) @(posedge hclk);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "register readback");
    end
    // A proper write of a5 to 5a, timed, with the completion interrupt.
    bus(1'b1, A_CTL, 32'h4);
    seq(8'h55, 8'haa, 8'h06);
    #1;
    check("busy after start", 32'h1, {31'h0, write_busy});
    wait_done();
    check("write length", WCYC, n);
    rd(A_CTL, 32'h4, "control after write");
    rd(A_IRQ, 32'hf, "flag after write");
    rd(A_IRQ, 32'hf, "flag held");
    check("irq raised", 32'h1, {31'h0, eeprom_irq});
    bus(1'b1, A_IRQ, 32'he);
    rd(A_IRQ, 32'he, "flag cleared");
    check("irq dropped", 32'h0, {31'h0, eeprom_irq});
    // Write-allow cleared while a write runs must not stop it.
    prep(8'h5b, 8'h3c);
    seq(8'h55, 8'haa, 8'h06);
    bus(1'b1, A_CTL, 32'h0);
    wait_done();
    ee_read(8'h5b, 8'h3c);
    rd(A_CTL, 32'h0, "read start cleared");
    ee_read(8'h5a, 8'ha5);
    // Start without write-allow, then three broken sequences.
    seq(8'h55, 8'haa, 8'h02);
    #1;
    check("busy without allow", 32'h0, {31'h0, write_busy});
    for (int i = 0; i < 3; i++) begin
      prep(8'h5a, 8'h11);
      bus(1'b1, A_UNL, {24'h0, k1s[i]});
      if (i == 0) begin
        bus(1'b0, A_DAT, 32'h0);
      end
      bus(1'b1, A_UNL, {24'h0, k2s[i]});
      bus(1'b1, A_CTL, 32'h6);
      #1;
      check("busy after bad unlock", 32'h0, {31'h0, write_busy});
    end
    ee_read(8'h5a, 8'ha5);
    // Each warm reset in mid-write aborts it and clears the data and address registers.
    for (int i = 0; i < 3; i++) begin
      prep(8'h5a, 8'h77);
      seq(8'h55, 8'haa, 8'h06);
      @(posedge hclk);
      {mrst, wrst, brst} <= 3'b100 >> i;
      @(posedge hclk);
      {mrst, wrst, brst} <= 3'b000;
      #1;
      check("busy after abort", 32'h0, {31'h0, write_busy});
      rd(A_CTL, 32'hc, "control after abort");
      rd(A_DAT, 32'h0, "data after abort");
      rd(A_ADR, 32'h0, "address after abort");
    end
    ee_read(8'h5a, 8'ha5);
    // Programmer port reads zero only while protected.
    prog_addr <= 8'h5b;
    repeat (2) @(posedge hclk);
    check("programmer protected", 32'h0, {24'h0, prog_rdata});
    fuse <= 1'b1;
    repeat (2) @(posedge hclk);
    check("programmer open", 32'h3c, {24'h0, prog_rdata});
    // A power-on reset in mid-run drops write-allow and restarts the hold-off.
    bus(1'b1, A_CTL, 32'h4);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(A_CTL, 32'h0, "control after power-on");
    bus(1'b1, A_CTL, 32'h4);
    seq(8'h55, 8'haa, 8'h06);
    #1;
    check("busy in second hold-off", 32'h0, {31'h0, write_busy});
    check("bus response", 32'h0, {31'h0, hresp});
    results();
  end
endmodule
